// >>> logic/msa_pkg.sv
// shared constants for the memory scan address and trigger block
package msa_pkg;

	////////////////////////////////////////////////////////////////
	// register byte addresses on the bus
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_CUR_HI = 8'h04;
	localparam logic [7:0] OFF_CUR_LO = 8'h08;
	localparam logic [7:0] OFF_END_HI = 8'h0C;
	localparam logic [7:0] OFF_END_LO = 8'h10;
	localparam logic [7:0] OFF_TRIG   = 8'h14;
	localparam logic [7:0] OFF_ISTAT  = 8'h18;
	localparam logic [7:0] OFF_ICLR   = 8'h1C;
	localparam logic [7:0] OFF_IEN    = 8'h20;

	////////////////////////////////////////////////////////////////
	// field positions and reset values
	localparam int CTL_EN   = 7;
	localparam int CTL_GO   = 6;
	localparam int CTL_INTERRUPT_HANDLING_SELECT = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_INV  = 1;
	localparam int IRQ_W    = 2;

	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_ADDR = 16'h0000;
	localparam logic [3:0]  RST_TRIGGER_SOURCE_FIELD = 4'h0;

	////////////////////////////////////////////////////////////////
	// access modes
	localparam logic [1:0] MODE_CONC  = 2'b00;
	localparam logic [1:0] MODE_BURST = 2'b01;
	localparam logic [1:0] MODE_PEEK  = 2'b10;
	localparam logic [1:0] MODE_TRIG  = 2'b11;

	// trigger select codes; the event vector is indexed by code
	localparam logic [3:0] TRIGGER_SOURCE_FIELD_LFO  = 4'h0;
	localparam logic [3:0] TRIGGER_SOURCE_FIELD_SMT2 = 4'h9;
	localparam int         TRIGGER_SOURCE_FIELD_NUM  = 10;

	// first address past implemented program memory
	localparam logic [15:0] PFM_END = 16'h4000;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	function automatic logic is_mapped(input logic [7:0] a);
		case (a)
			OFF_CTRL, OFF_CUR_HI, OFF_CUR_LO, OFF_END_HI,
			OFF_END_LO, OFF_TRIG, OFF_ISTAT, OFF_ICLR,
			OFF_IEN: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

endpackage

// >>> logic/msa_axil.sv
// axi4-lite slave front end for the scan register bytes
`timescale 1ns/1ps
module msa_axil (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             wr_en,
	output logic [7:0]       wr_addr,
	output logic [7:0]       wr_data,
	output logic [7:0]       rd_addr,
	input  wire logic [7:0]  rd_data
);
	logic       aw_full_r;
	logic       w_full_r;
	logic       w_strb_r;
	logic [7:0] aw_addr_r;
	logic [7:0] w_data_r;
	logic       do_wr;

	// address and data may arrive in either order
	assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_wr   = ce && aw_full_r && w_full_r;
	assign wr_en   = do_wr && w_strb_r;
	assign wr_addr = aw_addr_r;
	assign wr_data = w_data_r;
	assign rd_addr = s_axi_araddr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= msa_pkg::RST_BYTE;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_full_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_r <= 1'b0;
			w_strb_r <= 1'b0;
			w_data_r <= msa_pkg::RST_BYTE;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				w_strb_r <= s_axi_wstrb[0];
				w_data_r <= s_axi_wdata[7:0];
			end else if (do_wr) begin
				w_full_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= msa_pkg::RESP_OKAY;
		end else if (ce) begin
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= msa_pkg::is_mapped(aw_addr_r) ?
					msa_pkg::RESP_OKAY : msa_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= msa_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h00_0000, rd_data};
				s_axi_rresp  <= msa_pkg::is_mapped(s_axi_araddr) ?
					msa_pkg::RESP_OKAY : msa_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// >>> logic/msa_trig.sv
// trigger source synchroniser, edge detect and selector
`timescale 1ns/1ps
module msa_trig (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic                         ce,
	input  wire logic [msa_pkg::TRIGGER_SOURCE_FIELD_NUM-1:0] ev_async,
	input  wire logic [3:0]                   sel,
	output logic                              trig_pulse
);
	logic [msa_pkg::TRIGGER_SOURCE_FIELD_NUM-1:0] s1_r;
	logic [msa_pkg::TRIGGER_SOURCE_FIELD_NUM-1:0] s2_r;
	logic [msa_pkg::TRIGGER_SOURCE_FIELD_NUM-1:0] s3_r;
	logic [msa_pkg::TRIGGER_SOURCE_FIELD_NUM-1:0] rise;

	// sources live on other peripheral clocks: two flops first
	for (genvar i = 0; i < msa_pkg::TRIGGER_SOURCE_FIELD_NUM; i++) begin : g_sync
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				s1_r[i] <= 1'b0;
				s2_r[i] <= 1'b0;
				s3_r[i] <= 1'b0;
			end else if (ce) begin
				s1_r[i] <= ev_async[i];
				s2_r[i] <= s1_r[i];
				s3_r[i] <= s2_r[i];
			end
		end
		assign rise[i] = s2_r[i] && !s3_r[i];
	end

	// codes above the last source are reserved and never fire
	always_comb begin
		trig_pulse = 1'b0;
		if (sel <= msa_pkg::TRIGGER_SOURCE_FIELD_SMT2)
			trig_pulse = ce && rise[sel];
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_trig_reserved;
		sel > msa_pkg::TRIGGER_SOURCE_FIELD_SMT2 |-> !trig_pulse;
	endproperty
	a_trig_reserved: assert property (p_trig_reserved)
		else $error("reserved trigger code produced an event");

	property p_trig_source;
		trig_pulse |-> $past(s1_r[sel], 1) && !$past(s2_r[sel], 1);
	endproperty
	a_trig_source: assert property (p_trig_source)
		else $error("trigger pulse not from the selected source");
endmodule

// >>> logic/msa_scan.sv
// memory scan address range, trigger select and fetch pacing
// Overview of operation
// - 16-bit current address from two bytes, plus one after each fetch.
// - address and end address writes are dropped while scan go is 1.
// - 16-bit end address from two bytes marks last scanned location.
// - trigger codes 0-9 pick oscillator, clock, timers, matches; rest reserved.
// - trigger select holds bits 3:0; bits 7:4 read as zero.
// - timers 2 and 4 give postscaled events, others give overflow.
// - scan go clears once current passes end with no fetch running.
// - invalid flag sets when address passes range or leaves memory.
// - mode 11 triggered, 10 peek, 01 burst, 00 concurrent.
// - enable low resets scanner state, other registers keep contents.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module msa_scan (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        low_frequency_oscillator,
	input  wire logic        reference_clock_output,
	input  wire logic        timer0_overflow_event,
	input  wire logic        timer1_overflow_event,
	input  wire logic        timer2_postscaled_event,
	input  wire logic        timer3_overflow_event,
	input  wire logic        timer4_postscaled_event,
	input  wire logic        timer5_overflow_event,
	input  wire logic        measurement_timer1_match,
	input  wire logic        measurement_timer2_match,
	input  wire logic        crc_ready,
	input  wire logic        cpu_in_interrupt,
	output logic             fetch_valid,
	input  wire logic        fetch_ready,
	output logic [15:0]      fetch_addr,
	output logic             cpu_stall,
	output logic             irq
);
	typedef enum logic {ST_IDLE, ST_FETCH} msa_fetch_e;

	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [7:0]  wr_data;
	logic [7:0]  rd_addr;
	logic [7:0]  rd_data;
	logic        trig_pulse;

	logic        en_r;
	logic        go_r;
	logic        interrupt_handling_select_r;
	logic [1:0]  mode_r;
	logic [15:0] cur_r;
	logic [15:0] end_r;
	logic [3:0]  trigger_source_field_r;
	logic        inv_r;
	logic        pend_r;
	logic [1:0]  st_r;
	logic [1:0]  ien_r;
	msa_fetch_e  state_r;

	logic        fire;
	logic        past_end;
	logic        out_pfm;
	logic        go_eff;
	logic        trig_mode;
	logic        start;
	logic        hw_done;
	logic        inv_nxt;
	logic        busy;
	logic [1:0]  ev;
	logic [1:0]  clr;

	function automatic logic wr_hit(input logic [7:0] off);
		wr_hit = wr_en && (wr_addr == off);
	endfunction

	////////////////////////////////////////////////////////////////
	msa_axil u_bus (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.ce            (ce),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data)
	);

	// event vector order follows the trigger select codes
	msa_trig u_trig (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.ce         (ce),
		.ev_async   ({measurement_timer2_match, measurement_timer1_match,
			timer5_overflow_event, timer4_postscaled_event,
			timer3_overflow_event, timer2_postscaled_event,
			timer1_overflow_event, timer0_overflow_event,
			reference_clock_output, low_frequency_oscillator}),
		.sel        (trigger_source_field_r),
		.trig_pulse (trig_pulse)
	);

	////////////////////////////////////////////////////////////////
	// pacing decisions
	assign fire      = (state_r == ST_FETCH) && fetch_ready;
	assign past_end  = cur_r > end_r;
	assign out_pfm   = cur_r >= msa_pkg::PFM_END;
	assign trig_mode = mode_r == msa_pkg::MODE_TRIG;
	// interrupt override masks go without clearing it; peek ignores it
	assign go_eff    = go_r && !(interrupt_handling_select_r && cpu_in_interrupt &&
		mode_r != msa_pkg::MODE_PEEK);
	assign start     = en_r && go_eff && (state_r == ST_IDLE) &&
		crc_ready && !past_end && !out_pfm &&
		(!trig_mode || pend_r);
	assign hw_done   = go_r && (state_r == ST_IDLE) &&
		(past_end || out_pfm);
	assign inv_nxt   = en_r && (past_end || out_pfm);
	assign busy      = (state_r == ST_FETCH) || (en_r && go_r && crc_ready);

	assign fetch_valid = state_r == ST_FETCH;
	assign fetch_addr  = cur_r;
	assign cpu_stall   = en_r && go_eff &&
		(mode_r == msa_pkg::MODE_BURST);

	////////////////////////////////////////////////////////////////
	// control byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_r   <= 1'b0;
			interrupt_handling_select_r <= 1'b0;
			mode_r <= msa_pkg::MODE_CONC;
		end else if (ce && wr_hit(msa_pkg::OFF_CTRL)) begin
			en_r   <= wr_data[msa_pkg::CTL_EN];
			interrupt_handling_select_r <= wr_data[msa_pkg::CTL_INTERRUPT_HANDLING_SELECT];
			mode_r <= wr_data[1:0];
		end
	end

	// hardware clear beats a software set in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			go_r <= 1'b0;
		else if (ce) begin
			if (hw_done)
				go_r <= 1'b0;
			else if (wr_hit(msa_pkg::OFF_CTRL))
				go_r <= wr_data[msa_pkg::CTL_GO];
		end
	end

	// no atomic pair update: software must write with go low
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cur_r <= msa_pkg::RST_ADDR;
		else if (ce) begin
			if (fire)
				cur_r <= cur_r + 16'h0001;
			else if (!go_r) begin
				if (wr_hit(msa_pkg::OFF_CUR_HI))
					cur_r[15:8] <= wr_data;
				if (wr_hit(msa_pkg::OFF_CUR_LO))
					cur_r[7:0] <= wr_data;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			end_r <= msa_pkg::RST_ADDR;
		else if (ce && !go_r) begin
			if (wr_hit(msa_pkg::OFF_END_HI))
				end_r[15:8] <= wr_data;
			if (wr_hit(msa_pkg::OFF_END_LO))
				end_r[7:0] <= wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			trigger_source_field_r <= msa_pkg::RST_TRIGGER_SOURCE_FIELD;
		else if (ce && wr_hit(msa_pkg::OFF_TRIG))
			trigger_source_field_r <= wr_data[3:0];
	end

	////////////////////////////////////////////////////////////////
	// scanner internal state, cleared while disabled
	always_ff @(posedge aclk) begin
		if (!aresetn)
			state_r <= ST_IDLE;
		else if (ce) begin
			case (state_r)
				ST_IDLE:  if (start) state_r <= ST_FETCH;
				ST_FETCH: if (fetch_ready || !en_r) state_r <= ST_IDLE;
				default:  state_r <= ST_IDLE;
			endcase
		end
	end

	// one event held at most; a second before the fetch is dropped
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pend_r <= 1'b0;
		else if (ce) begin
			if (!en_r || !go_r || !trig_mode)
				pend_r <= 1'b0;
			else if (start)
				pend_r <= trig_pulse;
			else if (trig_pulse)
				pend_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			inv_r <= 1'b0;
		else if (ce)
			inv_r <= inv_nxt;
	end

	////////////////////////////////////////////////////////////////
	// interrupt status, enable and write-one clear
	assign ev[msa_pkg::IRQ_DONE] = hw_done;
	assign ev[msa_pkg::IRQ_INV]  = inv_nxt && !inv_r;
	assign clr = wr_hit(msa_pkg::OFF_ICLR) ? wr_data[1:0] : 2'b00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r  <= 2'b00;
			ien_r <= 2'b00;
		end else if (ce) begin
			st_r <= (st_r & ~clr) | ev;
			if (wr_hit(msa_pkg::OFF_IEN))
				ien_r <= wr_data[1:0];
		end
	end

	assign irq = |(st_r & ien_r);

	////////////////////////////////////////////////////////////////
	always_comb begin
		case (rd_addr)
			msa_pkg::OFF_CTRL:   rd_data = {en_r, go_r, busy, inv_r,
				interrupt_handling_select_r, 1'b0, mode_r};
			msa_pkg::OFF_CUR_HI: rd_data = cur_r[15:8];
			msa_pkg::OFF_CUR_LO: rd_data = cur_r[7:0];
			msa_pkg::OFF_END_HI: rd_data = end_r[15:8];
			msa_pkg::OFF_END_LO: rd_data = end_r[7:0];
			msa_pkg::OFF_TRIG:   rd_data = {4'h0, trigger_source_field_r};
			msa_pkg::OFF_ISTAT:  rd_data = {6'h00, st_r};
			msa_pkg::OFF_IEN:    rd_data = {6'h00, ien_r};
			default:             rd_data = msa_pkg::RST_BYTE;
		endcase
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_inc;
		ce && fire |=> cur_r == $past(cur_r) + 16'h0001;
	endproperty
	a_inc: assert property (p_inc)
		else $error("address did not step by one after a fetch");

	property p_lock;
		ce && go_r && !fire && wr_hit(msa_pkg::OFF_CUR_LO)
			|=> cur_r == $past(cur_r);
	endproperty
	a_lock: assert property (p_lock)
		else $error("address byte written while scan go set");

	property p_end_lock;
		ce && go_r |=> end_r == $past(end_r);
	endproperty
	a_end_lock: assert property (p_end_lock)
		else $error("end address changed while scan go set");

	property p_trig_rd;
		rd_addr == msa_pkg::OFF_TRIG |-> rd_data[7:4] == 4'h0;
	endproperty
	a_trig_rd: assert property (p_trig_rd)
		else $error("trigger select upper bits not zero");

	property p_go_clr;
		ce && go_r && state_r == ST_IDLE && past_end |=> !go_r;
	endproperty
	a_go_clr: assert property (p_go_clr)
		else $error("scan go not cleared past end address");

	property p_inv;
		ce && en_r && fire && cur_r == end_r ##1 ce |=> inv_r;
	endproperty
	a_inv: assert property (p_inv)
		else $error("invalid flag missing after passing end");

	property p_trig_gate;
		start && trig_mode |-> pend_r && crc_ready;
	endproperty
	a_trig_gate: assert property (p_trig_gate)
		else $error("triggered fetch started without an event");

	property p_disable;
		ce && !en_r |=> state_r == ST_IDLE && !pend_r;
	endproperty
	a_disable: assert property (p_disable)
		else $error("scanner state kept while disabled");

	property p_trig_fetch;
		ce && start |=> fetch_valid && fetch_addr == $past(cur_r);
	endproperty
	a_trig_fetch: assert property (p_trig_fetch)
		else $error("fetch did not follow its start");
endmodule

// >>> test/msa_mem_model.sv
// flash and crc client stand-in on the fetch side of the scanner
`timescale 1ns/1ps
module msa_mem_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        fetch_valid,
	input  wire logic [15:0] fetch_addr,
	output logic             fetch_ready,
	input  wire logic        crc_hold,
	output logic             crc_ready,
	input  wire logic [3:0]  lat,
	output int               count,
	output logic [15:0]      last_addr
);
	logic [3:0] wait_r;

	// crc engine only stalls when the bench asks it to
	assign crc_ready = !crc_hold;

	////////////////////////////////////////////////////////////////
	// flash answers lat+1 cycles after a fetch appears, ready only while a fetch waits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fetch_ready <= 1'b0;
			wait_r      <= 4'h0;
			count       <= 0;
			last_addr   <= 16'h0000;
		end else if (fetch_valid && fetch_ready) begin
			fetch_ready <= 1'b0;
			wait_r      <= 4'h0;
			count       <= count + 1;
			last_addr   <= fetch_addr;
		end else if (fetch_valid) begin
			wait_r      <= wait_r + 4'h1;
			fetch_ready <= wait_r >= lat;
		end else begin
			fetch_ready <= 1'b0;
			wait_r      <= 4'h0;
		end
	end
endmodule

// >>> test/tb.sv
// register and fetch tests for the scan address and trigger block
`timescale 1ns/1ps
module tb;
	logic        aclk, aresetn, ce, cpu_in_interrupt;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_v, rs;
	logic [3:0]  s_axi_wstrb, lat;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [9:0]  ev;
	logic        crc_hold, crc_ready, fetch_valid, fetch_ready;
	logic [15:0] fetch_addr, last_addr;
	logic        cpu_stall, irq;
	int          count, failures, num_checks, cycles, c0;

	msa_scan dut_u (
		.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready,
		.low_frequency_oscillator(ev[0]), .reference_clock_output(ev[1]),
		.timer0_overflow_event(ev[2]), .timer1_overflow_event(ev[3]),
		.timer2_postscaled_event(ev[4]), .timer3_overflow_event(ev[5]),
		.timer4_postscaled_event(ev[6]), .timer5_overflow_event(ev[7]),
		.measurement_timer1_match(ev[8]), .measurement_timer2_match(ev[9]),
		.crc_ready, .cpu_in_interrupt, .fetch_valid, .fetch_ready,
		.fetch_addr, .cpu_stall, .irq
	);

	msa_mem_model mem_u (
		.aclk, .aresetn, .fetch_valid, .fetch_addr, .fetch_ready,
		.crc_hold, .crc_ready, .lat, .count, .last_addr
	);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// channels sampled at the rising edge; bready and rready stay high
	// all run, so back-to-back calls never drive them twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic b;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(posedge aclk);
			b  = s_axi_bvalid;
			rs = 32'(s_axi_bresp);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
	endtask

	task automatic rd(input logic [7:0] a);
		logic g;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		g = 1'b0;
		while (!g) begin
			@(posedge aclk);
			g    = s_axi_rvalid;
			rd_v = s_axi_rdata;
			rs   = 32'(s_axi_rresp);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rd_v, exp);
	endtask

	task automatic set_rng(input logic [15:0] c, input logic [15:0] e);
		wr(msa_pkg::OFF_CUR_HI, c[15:8]);
		wr(msa_pkg::OFF_CUR_LO, c[7:0]);
		wr(msa_pkg::OFF_END_HI, e[15:8]);
		wr(msa_pkg::OFF_END_LO, e[7:0]);
	endtask

	// event sources are async levels; held two cycles to pass the sync
	task automatic pulse(input logic [9:0] m);
		ev <= m;
		repeat (2) @(posedge aclk);
		ev <= 10'h000;
		repeat (12) @(posedge aclk);
	endtask

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			failures++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		aresetn = 1'b0; ce = 1'b1; cpu_in_interrupt = 1'b0;
		s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0;
		s_axi_wdata = 32'h0000_0000; s_axi_wstrb = 4'hF;
		s_axi_bready = 1'b1; s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b1; ev = 10'h000; crc_hold = 1'b0; lat = 4'h3;
		failures = 0; num_checks = 0; cycles = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);

		for (int i = 0; i < 9; i++) begin
			rc(8'(4 * i), 32'h0000_0000);
		end
		chk(rs, 32'(msa_pkg::RESP_OKAY));
		rc(8'h24, 32'h0000_0000);
		chk(rs, 32'(msa_pkg::RESP_SLVERR));
		wr(8'h24, 8'hFF);
		chk(rs, 32'(msa_pkg::RESP_SLVERR));
		set_rng(16'h1234, 16'hABCD);
		wr(msa_pkg::OFF_TRIG, 8'hFF);
		chk(rs, 32'(msa_pkg::RESP_OKAY));
		rc(msa_pkg::OFF_CUR_HI, 32'h0000_0012);
		rc(msa_pkg::OFF_CUR_LO, 32'h0000_0034);
		rc(msa_pkg::OFF_END_HI, 32'h0000_00AB);
		rc(msa_pkg::OFF_END_LO, 32'h0000_00CD);
		rc(msa_pkg::OFF_TRIG, 32'h0000_000F);
		$display("test registers done");

		// last word of memory: end is reached and address leaves memory
		set_rng(16'h3FFE, 16'h3FFF);
		wr(msa_pkg::OFF_IEN, 8'h03);
		wr(msa_pkg::OFF_CTRL, 8'hC0);
		while (count < 2) @(posedge aclk);
		repeat (4) @(posedge aclk);
		chk(32'(last_addr), 32'h0000_3FFF);
		rc(msa_pkg::OFF_CTRL, 32'h0000_0090);
		chk(32'(count), 32'h0000_0002);
		rc(msa_pkg::OFF_CUR_HI, 32'h0000_0040);
		rc(msa_pkg::OFF_CUR_LO, 32'h0000_0000);
		rc(msa_pkg::OFF_ISTAT, 32'h0000_0003);
		chk(32'(irq), 32'h0000_0001);
		wr(msa_pkg::OFF_ICLR, 8'h01);
		rc(msa_pkg::OFF_ISTAT, 32'h0000_0002);
		chk(32'(irq), 32'h0000_0001);
		wr(msa_pkg::OFF_IEN, 8'h01);
		chk(32'(irq), 32'h0000_0000);
		wr(msa_pkg::OFF_ICLR, 8'h02);
		rc(msa_pkg::OFF_ISTAT, 32'h0000_0000);
		$display("test concurrent scan done");

		// crc stalled so the scan stays running while writes are tried
		crc_hold <= 1'b1;
		set_rng(16'h0010, 16'h0012);
		wr(msa_pkg::OFF_CTRL, 8'hC0);
		c0 = count;
		set_rng(16'h6655, 16'h7777);
		rc(msa_pkg::OFF_CUR_HI, 32'h0000_0000);
		rc(msa_pkg::OFF_CUR_LO, 32'h0000_0010);
		rc(msa_pkg::OFF_END_LO, 32'h0000_0012);
		chk(32'(count), 32'(c0));
		wr(msa_pkg::OFF_CTRL, 8'h40);
		rc(msa_pkg::OFF_CTRL, 32'h0000_0040);
		rc(msa_pkg::OFF_CUR_LO, 32'h0000_0010);
		// interrupt mask holds go off in concurrent mode, not in peek
		cpu_in_interrupt <= 1'b1;
		crc_hold <= 1'b0;
		wr(msa_pkg::OFF_CTRL, 8'hC8);
		repeat (20) @(posedge aclk);
		chk(32'(count), 32'(c0));
		rc(msa_pkg::OFF_CTRL, 32'h0000_00E8);
		wr(msa_pkg::OFF_CTRL, 8'hCA);
		while (count < c0 + 1) @(posedge aclk);
		cpu_in_interrupt <= 1'b0;
		wr(msa_pkg::OFF_CTRL, 8'hC1);
		chk(32'(cpu_stall), 32'h0000_0001);
		while (count < c0 + 3) @(posedge aclk);
		repeat (4) @(posedge aclk);
		chk(32'(last_addr), 32'h0000_0012);
		chk(32'(count), 32'(c0 + 3));
		rc(msa_pkg::OFF_CTRL, 32'h0000_0091);
		chk(32'(cpu_stall), 32'h0000_0000);
		$display("test lock and burst done");

		// one fetch per selected event, none for the next source or for reserved code 0x0A
		lat <= 4'h0;
		set_rng(16'h0100, 16'h01FF);
		wr(msa_pkg::OFF_CTRL, 8'hC3);
		for (int i = 0; i < 10; i++) begin
			wr(msa_pkg::OFF_TRIG, 8'(i));
			c0 = count;
			pulse(10'h001 << ((i + 1) % 10));
			chk(32'(count), 32'(c0));
			pulse(10'h001 << i);
			chk(32'(count), 32'(c0 + 1));
			chk(32'(last_addr), 32'(16'h0100 + i));
		end
		wr(msa_pkg::OFF_TRIG, 8'h0A);
		c0 = count;
		pulse(10'h3FF);
		chk(32'(count), 32'(c0));
		wr(msa_pkg::OFF_CTRL, 8'h00);
		$display("test triggered mode done");
		print_verdict();
	end
endmodule
